// ### verilog/host_port_pkg.sv
// shared constants and types for the host port and data helper block
package host_port_pkg;
  // =====================================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned ACK_NS = 500;
  localparam int unsigned ACK_CYCLES = (ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACK_CNT_W = 8;
  // =====================================================================
  // serial rates, bits per second, selected by a 3-bit code
  localparam int unsigned BAUD_OVERSAMPLE = 16;
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_57600 = 57600;
  localparam int unsigned BAUD_DIV_W = 16;
  // =====================================================================
  // data helper widths
  localparam int unsigned WORD_W = 32;
  localparam int unsigned ROT_N = 32;
  localparam int unsigned ROT_IDX_W = 5;
  // =====================================================================
  // reset values
  localparam logic DMA_PATH_RESET = 1'b1;
  // =====================================================================
  // state machines
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_STORE = 2'b01,
    P_ACK = 2'b10,
    P_WAIT = 2'b11
  } port_state_t;
  typedef enum logic [1:0] {
    V_IDLE = 2'b00,
    V_REQ = 2'b01,
    V_WAIT = 2'b10
  } video_state_t;
endpackage : host_port_pkg

// ### verilog/host_port_and_data_ops.sv
// parallel receive port, serial rate divider, settings bit port, data helpers, video mover
module host_port_and_data_ops
  import host_port_pkg::*;
#(
  parameter int unsigned CLK_HZ = 200_000_000,
  parameter int unsigned ADDR_W = 24,
  parameter int unsigned LINE_W = 10,
  parameter int unsigned VBUF_W = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] host_data,
  input wire logic host_strobe_n,
  output logic host_busy,
  output logic host_ack_n,
  input wire logic cpu_special_mode,
  input wire logic cpu_normal_mode,
  input wire logic cpu_ack_req,
  input wire logic cpu_busy_release,
  input wire logic cpu_irq_clear,
  output logic dma_path,
  output logic [7:0] latch_data,
  output logic host_irq,
  output logic [7:0] mem_data,
  output logic mem_valid,
  input wire logic mem_ready,
  output logic buf_empty,
  input wire logic [2:0] baud_sel,
  output logic baud_tick,
  input wire logic nv_access,
  input wire logic nv_clk_set,
  input wire logic nv_data_set,
  input wire logic nv_drive_set,
  output logic nv_clk_out,
  output logic nv_data_out,
  output logic nv_data_oe,
  input wire logic nv_data_in,
  output logic nv_bit,
  input wire logic rot_wr,
  input wire logic [ROT_IDX_W-1:0] rot_widx,
  input wire logic [WORD_W-1:0] rot_wdata,
  input wire logic [ROT_IDX_W-1:0] rot_ridx,
  output logic [WORD_W-1:0] rot_rdata,
  input wire logic op_wr,
  input wire logic [2*WORD_W-1:0] op_wdata,
  output logic [2*WORD_W-1:0] expand_result,
  output logic [WORD_W-1:0] shrink_result,
  output logic [WORD_W-1:0] mirror_result,
  input wire logic video_start,
  input wire logic [ADDR_W-1:0] video_base,
  input wire logic [LINE_W-1:0] video_line_words,
  input wire logic beam_detect_n,
  output logic dram_req,
  output logic [ADDR_W-1:0] dram_addr,
  input wire logic dram_ready,
  input wire logic dram_rvalid,
  input wire logic [WORD_W-1:0] dram_rdata,
  output logic vbuf_we,
  output logic [VBUF_W-1:0] vbuf_addr,
  output logic [WORD_W-1:0] vbuf_wdata,
  output logic video_line_done
);
  // =====================================================================
  // pin synchronisers; data is held stable before the strobe, so it settles
  // through its own two stages ahead of the synced strobe edge
  logic [7:0] data_s1, data_s2;
  logic strobe_s1, strobe_s2, strobe_s3;
  logic bd_s1, bd_s2, bd_s3;
  logic nv_s1, nv_s2;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
      strobe_s1 <= 1'b1;
      strobe_s2 <= 1'b1;
      strobe_s3 <= 1'b1;
      bd_s1 <= 1'b1;
      bd_s2 <= 1'b1;
      bd_s3 <= 1'b1;
      nv_s1 <= 1'b0;
      nv_s2 <= 1'b0;
    end else begin
      data_s1 <= host_data;
      data_s2 <= data_s1;
      strobe_s1 <= host_strobe_n;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      bd_s1 <= beam_detect_n;
      bd_s2 <= bd_s1;
      bd_s3 <= bd_s2;
      nv_s1 <= nv_data_in;
      nv_s2 <= nv_s1;
    end
  end
  logic strobe_fall;
  logic bd_fall;
  assign strobe_fall = strobe_s3 & ~strobe_s2;
  assign bd_fall = bd_s3 & ~bd_s2;
  // =====================================================================
  // storing path select
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dma_path <= DMA_PATH_RESET;
    end else if (cpu_special_mode) begin
      dma_path <= 1'b0;
    end else if (cpu_normal_mode) begin
      dma_path <= 1'b1;
    end
  end
  // =====================================================================
  // two-entry buffer toward memory; a full buffer holds busy, so the host stalls
  logic [7:0] entry1;
  logic valid1;
  logic push, pop, fifo_in_ready;
  logic [7:0] push_data;
  logic next_valid0, next_valid1;
  logic [7:0] next_entry0, next_entry1;
  assign fifo_in_ready = ~valid1;
  assign pop = mem_valid & mem_ready;
  always_comb begin
    next_valid0 = mem_valid;
    next_valid1 = valid1;
    next_entry0 = mem_data;
    next_entry1 = entry1;
    if (pop) begin
      next_valid0 = valid1;
      next_entry0 = entry1;
      next_valid1 = 1'b0;
    end
    if (push) begin
      if (!next_valid0) begin
        next_valid0 = 1'b1;
        next_entry0 = push_data;
      end else begin
        next_valid1 = 1'b1;
        next_entry1 = push_data;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mem_valid <= 1'b0;
      valid1 <= 1'b0;
      mem_data <= 8'h00;
      entry1 <= 8'h00;
      buf_empty <= 1'b1;
    end else begin
      mem_valid <= next_valid0;
      valid1 <= next_valid1;
      mem_data <= next_entry0;
      entry1 <= next_entry1;
      buf_empty <= ~next_valid0;
    end
  end
  // =====================================================================
  // parallel port handshake
  port_state_t port_state;
  logic [ACK_CNT_W-1:0] ack_count;
  logic ack_start;
  assign push = (port_state == P_STORE) & fifo_in_ready;
  assign push_data = latch_data;
  assign ack_start = push | ((port_state == P_WAIT) & cpu_ack_req);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_state <= P_IDLE;
      host_busy <= 1'b0;
      latch_data <= 8'h00;
    end else begin
      case (port_state)
        P_IDLE: begin
          if (strobe_fall) begin
            host_busy <= 1'b1;
            latch_data <= data_s2;
            port_state <= dma_path ? P_STORE : P_WAIT;
          end
        end
        P_STORE: begin
          if (fifo_in_ready) begin
            port_state <= P_ACK;
          end
        end
        P_ACK: begin
          if (ack_count == '0 && host_ack_n) begin
            host_busy <= 1'b0;
            port_state <= P_IDLE;
          end
        end
        P_WAIT: begin
          if (cpu_busy_release) begin
            host_busy <= 1'b0;
            port_state <= P_IDLE;
          end
        end
        default: port_state <= P_IDLE;
      endcase
    end
  end
  // ack pulse width is fixed; the cpu only decides when it starts in latch mode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_count <= '0;
      host_ack_n <= 1'b1;
    end else if (ack_start) begin
      ack_count <= ACK_CNT_W'(ACK_CYCLES - 1);
      host_ack_n <= 1'b0;
    end else if (ack_count != '0) begin
      ack_count <= ack_count - 1'b1;
    end else begin
      host_ack_n <= 1'b1;
    end
  end
  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      host_irq <= 1'b0;
    end else if (port_state == P_IDLE && strobe_fall && !dma_path) begin
      host_irq <= 1'b1;
    end else if (cpu_irq_clear) begin
      host_irq <= 1'b0;
    end
  end
  // =====================================================================
  // serial rate divider, one tick per oversample period
  function automatic logic [BAUD_DIV_W-1:0] baud_div(input logic [2:0] sel);
    int unsigned rate;
    case (sel)
      3'h0: rate = BAUD_1200;
      3'h1: rate = BAUD_2400;
      3'h2: rate = BAUD_4800;
      3'h3: rate = BAUD_9600;
      3'h4: rate = BAUD_19200;
      3'h5: rate = BAUD_38400;
      default: rate = BAUD_57600;
    endcase
    return BAUD_DIV_W'(CLK_HZ / (BAUD_OVERSAMPLE * rate) - 1);
  endfunction : baud_div
  logic [BAUD_DIV_W-1:0] baud_count;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      baud_count <= '0;
      baud_tick <= 1'b0;
    end else if (baud_count >= baud_div(baud_sel)) begin
      baud_count <= '0;
      baud_tick <= 1'b1;
    end else begin
      baud_count <= baud_count + 1'b1;
      baud_tick <= 1'b0;
    end
  end
  // =====================================================================
  // settings store: firmware moves one bit per access
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nv_clk_out <= 1'b0;
      nv_data_out <= 1'b0;
      nv_data_oe <= 1'b0;
      nv_bit <= 1'b0;
    end else begin
      nv_bit <= nv_s2;
      if (nv_access) begin
        nv_clk_out <= nv_clk_set;
        nv_data_out <= nv_data_set;
        nv_data_oe <= nv_drive_set;
      end
    end
  end
  // =====================================================================
  // rotate block; readback is a live transpose, so no start command exists
  logic [WORD_W-1:0] rot_mem [ROT_N];
  genvar gi;
  generate
    for (gi = 0; gi < ROT_N; gi++) begin : g_rot
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          rot_mem[gi] <= '0;
          rot_rdata[gi] <= 1'b0;
        end else begin
          if (rot_wr && rot_widx == ROT_IDX_W'(gi)) begin
            rot_mem[gi] <= rot_wdata;
          end
          rot_rdata[gi] <= rot_mem[gi][rot_ridx];
        end
      end
    end
  endgenerate
  // =====================================================================
  // expand doubles each bit, shrink ors each pair, mirror reverses and inverts
  logic [2*WORD_W-1:0] next_expand;
  logic [WORD_W-1:0] next_shrink, next_mirror;
  always_comb begin
    next_expand = '0;
    next_shrink = '0;
    next_mirror = '0;
    for (int i = 0; i < WORD_W; i++) begin
      next_expand[2*i] = op_wdata[i];
      next_expand[2*i+1] = op_wdata[i];
      next_shrink[i] = op_wdata[2*i] | op_wdata[2*i+1];
      next_mirror[WORD_W-1-i] = ~op_wdata[i];
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      expand_result <= '0;
      shrink_result <= '0;
      mirror_result <= '0;
    end else if (op_wr) begin
      expand_result <= next_expand;
      shrink_result <= next_shrink;
      mirror_result <= next_mirror;
    end
  end
  // =====================================================================
  // video mover: one line per beam detect, one read outstanding at a time
  video_state_t video_state;
  logic armed;
  logic [LINE_W-1:0] word_count;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      video_state <= V_IDLE;
      armed <= 1'b0;
      word_count <= '0;
      dram_req <= 1'b0;
      dram_addr <= '0;
      vbuf_we <= 1'b0;
      vbuf_addr <= '0;
      vbuf_wdata <= '0;
      video_line_done <= 1'b0;
    end else begin
      vbuf_we <= 1'b0;
      video_line_done <= 1'b0;
      if (video_start) begin
        armed <= 1'b1;
        dram_addr <= video_base;
      end
      case (video_state)
        V_IDLE: begin
          if (armed && bd_fall && video_line_words != '0) begin
            word_count <= '0;
            dram_req <= 1'b1;
            video_state <= V_REQ;
          end
        end
        V_REQ: begin
          if (dram_ready) begin
            dram_req <= 1'b0;
            video_state <= V_WAIT;
          end
        end
        V_WAIT: begin
          if (dram_rvalid) begin
            vbuf_we <= 1'b1;
            vbuf_addr <= VBUF_W'(word_count);
            vbuf_wdata <= dram_rdata;
            dram_addr <= dram_addr + 1'b1;
            word_count <= word_count + 1'b1;
            if (word_count + 1'b1 == video_line_words) begin
              video_line_done <= 1'b1;
              video_state <= V_IDLE;
            end else begin
              dram_req <= 1'b1;
              video_state <= V_REQ;
            end
          end
        end
        default: video_state <= V_IDLE;
      endcase
    end
  end
endmodule : host_port_and_data_ops

// ### test/host_port_checker.sv
// concurrent checks on the host port outputs and the mirror helper result
module host_port_checker
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_busy,
  input wire logic host_ack_n,
  input wire logic dma_path,
  input wire logic host_irq,
  input wire logic mem_valid,
  input wire logic buf_empty,
  input wire logic cpu_special_mode,
  input wire logic cpu_busy_release,
  input wire logic op_wr,
  input wire logic [2*WORD_W-1:0] op_wdata,
  input wire logic [WORD_W-1:0] mirror_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] low_cnt;
  // =====================================================================
  // helper logic
  always_ff @(posedge clk) begin
    if (!reset_n || host_ack_n) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  function automatic logic [31:0] flip(input logic [63:0] w);
    for (int i = 0; i < 32; i++) begin
      flip[31-i] = ~w[i];
    end
  endfunction : flip
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // =====================================================================
  // assertions
  property p_ack_width;
    $rose(host_ack_n) |-> int'(low_cnt) == ACK_CYCLES;
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("ack pulse width");
  property p_busy_drop;
    $rose(host_ack_n) && dma_path |=> !host_busy;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("busy after ack");
  property p_store_ack;
    $fell(host_ack_n) && dma_path |-> mem_valid && host_busy;
  endproperty
  a_store_ack: assert property (p_store_ack) else $error("ack before store");
  property p_empty;
    buf_empty == !mem_valid;
  endproperty
  a_empty: assert property (p_empty) else $error("empty flag wrong");
  // a byte lands in an empty buffer only while the host is held and acknowledged
  property p_store_flag;
    $fell(buf_empty) |-> host_busy && !host_ack_n;
  endproperty
  a_store_flag: assert property (p_store_flag) else $error("empty flag fell alone");
  property p_dma_reset;
    $rose(reset_n) |-> dma_path;
  endproperty
  a_dma_reset: assert property (p_dma_reset) else $error("path after reset");
  property p_special;
    cpu_special_mode |=> !dma_path;
  endproperty
  a_special: assert property (p_special) else $error("dma path not off");
  property p_latch_irq;
    $rose(host_busy) && !dma_path |-> host_irq;
  endproperty
  a_latch_irq: assert property (p_latch_irq) else $error("no irq at strobe");
  property p_latch_busy;
    host_busy && !dma_path && !cpu_busy_release |=> host_busy;
  endproperty
  a_latch_busy: assert property (p_latch_busy) else $error("busy dropped alone");
  property p_mirror;
    $past(op_wr) |-> mirror_result == flip($past(op_wdata));
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror result");
endmodule : host_port_checker
bind host_port_and_data_ops host_port_checker CHK (
  .clk(clk),
  .reset_n(reset_n),
  .host_busy(host_busy),
  .host_ack_n(host_ack_n),
  .dma_path(dma_path),
  .host_irq(host_irq),
  .mem_valid(mem_valid),
  .buf_empty(buf_empty),
  .cpu_special_mode(cpu_special_mode),
  .cpu_busy_release(cpu_busy_release),
  .op_wr(op_wr),
  .op_wdata(op_wdata),
  .mirror_result(mirror_result)
);

// ### test/host_model.sv
// host computer model driving the parallel receive port
module host_model (
  input wire logic clk,
  input wire logic busy,
  output logic [7:0] data,
  output logic strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    data = 8'hA5;
    strobe_n = 1'b1;
  end
  // byte first, strobe after, only once the port is free
  task automatic send(input logic [7:0] b, output bit to);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    to = (n >= 3000);
    @(negedge clk);
    data = b;
    repeat (4) @(negedge clk);
    strobe_n = 1'b0;
    repeat (2) @(negedge clk);
    strobe_n = 1'b1;
    repeat (2) @(negedge clk);
    // a real host moves on, so the lines stop showing the byte
    data = ~b;
    repeat (3) @(negedge clk);
  endtask : send
endmodule : host_model

// ### test/test_host_port_and_data_ops.sv
// self-checking bench for the host port and data helpers
module test_host_port_and_data_ops;
  import host_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HZ = 3_686_400;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cpu_special_mode = 1'b0, cpu_normal_mode = 1'b0, cpu_ack_req = 1'b0;
  logic cpu_busy_release = 1'b0, cpu_irq_clear = 1'b0, mem_ready = 1'b0;
  logic rot_wr = 1'b0, op_wr = 1'b0;
  logic nv_access = 1'b0, nv_clk_set = 1'b0, nv_data_set = 1'b0;
  logic nv_drive_set = 1'b0, store_bit = 1'b1;
  logic video_start = 1'b0, beam_detect_n = 1'b1, dram_ready = 1'b0, dram_rvalid = 1'b0;
  logic [2:0] baud_sel = 3'h0;
  logic [4:0] rot_widx = 5'h00, rot_ridx = 5'h00;
  logic [31:0] rot_wdata = 32'h0, dram_rdata = 32'h0, w[32], e, m;
  logic [63:0] op_wdata = 64'h0, ee;
  logic [23:0] video_base = 24'h0, ad;
  logic [9:0] video_line_words = 10'h000;
  logic host_busy, host_ack_n, dma_path, host_irq, mem_valid, buf_empty, baud_tick;
  logic nv_clk_out, nv_data_out, nv_data_oe, nv_bit, dram_req, vbuf_we, video_line_done;
  logic [7:0] host_data, latch_data, mem_data, b;
  logic [31:0] rot_rdata, shrink_result, mirror_result, vbuf_wdata;
  logic [63:0] expand_result;
  logic [23:0] dram_addr;
  logic [9:0] vbuf_addr;
  logic host_strobe_n;
  // settings store line has a pull-up; the device wins while it drives
  wire logic nv_data_in = (nv_data_oe === 1'b1) ? nv_data_out : store_bit;
  logic [7:0] exp_q[$];
  logic [63:0] vq[$];
  int bad_count = 0, checks = 0, n;
  bit to;
  int unsigned rate[8] = '{BAUD_1200, BAUD_2400, BAUD_4800, BAUD_9600,
                           BAUD_19200, BAUD_38400, BAUD_57600, BAUD_57600};
  host_port_and_data_ops #(.CLK_HZ(HZ)) DUT (.*);
  host_model HOST (.clk(clk), .busy(host_busy), .data(host_data), .strobe_n(host_strobe_n));
  always #2.5 clk = ~clk;
  // =====================================================================
  // shared tasks
  task automatic test_done;
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      $display("MISMATCH t=%0t wait ran out", $time);
      test_done();
    end
  endtask : wait_for
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic give(input logic [7:0] v);
    HOST.send(v, to);
    if (to) begin
      bad_count++;
      $display("MISMATCH t=%0t host wait ran out", $time);
      test_done();
    end
  endtask : give
  // =====================================================================
  // result watcher and dram side
  always @(posedge clk) begin
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      chk(mem_data, (exp_q.size() > 0) ? exp_q.pop_front() : ~mem_data);
    end
    if (vbuf_we === 1'b1) begin
      chk({vbuf_addr, vbuf_wdata}, (vq.size() > 0) ? vq.pop_front() : 64'h1);
    end
  end
  always begin : dram_side
    @(negedge clk);
    dram_rvalid = 1'b0;
    dram_rdata = $urandom;
    if (dram_req === 1'b1) begin
      repeat ($urandom_range(2)) @(negedge clk);
      dram_ready = 1'b1;
      ad = dram_addr;
      @(negedge clk);
      dram_ready = 1'b0;
      repeat ($urandom_range(2)) @(negedge clk);
      dram_rvalid = 1'b1;
      dram_rdata = 32'h5A5A0000 ^ {8'h00, ad};
    end
  end
  // =====================================================================
  // main sequence
  initial begin
    void'($urandom(32'h846A36DC));
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(dma_path, 1'b1);
    // receiver stalled: the third byte must wait for room
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      give(b);
    end
    repeat (20) @(negedge clk);
    chk({host_busy, buf_empty}, 2'h2);
    mem_ready = 1'b1;
    wait_for(host_busy, 1'b0);
    wait_for(buf_empty, 1'b1);
    mem_ready = 1'b0;
    chk(exp_q.size(), 0);
    // latch path: firmware answers the host
    pulse(cpu_special_mode);
    chk(dma_path, 1'b0);
    b = 8'($urandom);
    give(b);
    wait_for(host_irq, 1'b1);
    repeat (20) @(negedge clk);
    chk({latch_data, host_busy, host_ack_n, mem_valid}, {b, 3'h6});
    pulse(cpu_ack_req);
    wait_for(host_ack_n, 1'b0);
    pulse(cpu_busy_release);
    @(negedge clk);
    chk(host_busy, 1'b0);
    pulse(cpu_irq_clear);
    @(negedge clk);
    chk(host_irq, 1'b0);
    wait_for(host_ack_n, 1'b1);
    pulse(cpu_normal_mode);
    chk(dma_path, 1'b1);
    // expand, shrink and mirror helpers
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      op_wr = 1'b1;
      op_wdata = (i == 0) ? 64'h00000000FFFF0001 : {$urandom, $urandom};
      @(negedge clk);
      op_wr = 1'b0;
      for (int j = 0; j < 32; j++) begin
        ee[2*j+:2] = {2{op_wdata[j]}};
        e[j] = op_wdata[2*j] | op_wdata[2*j+1];
        m[31-j] = ~op_wdata[j];
      end
      chk(expand_result, ee);
      chk(shrink_result, e);
      chk(mirror_result, m);
    end
    // rotate: load a block, read columns with no further command
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      w[i] = $urandom;
      rot_wr = 1'b1;
      rot_widx = 5'(i);
      rot_wdata = w[i];
    end
    @(negedge clk);
    rot_wr = 1'b0;
    for (int j = 0; j < 32; j += 7) begin
      rot_ridx = 5'(j);
      @(negedge clk);
      for (int i = 0; i < 32; i++) begin
        e[i] = w[i][j];
      end
      chk(rot_rdata, e);
    end
    // every serial rate code, period between ticks
    for (int c = 0; c < 8; c++) begin
      baud_sel = 3'(c);
      wait_for(baud_tick, 1'b1);
      @(negedge clk);
      wait_for(baud_tick, 1'b1);
      @(negedge clk);
      wait_for(baud_tick, 1'b1);
      chk(n + 1, HZ / (BAUD_OVERSAMPLE * rate[c]));
    end
    // settings store pin levels, one bit per access
    {nv_clk_set, nv_data_set, nv_drive_set} = 3'h1;
    pulse(nv_access);
    store_bit = 1'b1;
    repeat (4) @(negedge clk);
    chk({nv_clk_out, nv_data_out, nv_data_oe, nv_bit}, 4'h2);
    {nv_clk_set, nv_data_set, nv_drive_set} = 3'h6;
    pulse(nv_access);
    // released line: the pull-up level must reach the polled bit
    store_bit = 1'b1;
    repeat (4) @(negedge clk);
    chk({nv_clk_out, nv_data_out, nv_data_oe, nv_bit}, 4'hD);
    // one line of image words, paced by beam detect
    video_base = 24'($urandom_range(60000));
    video_line_words = 10'h003;
    for (int k = 0; k < 3; k++) begin
      vq.push_back({22'h000000, 10'(k), 32'h5A5A0000 ^ {8'h00, video_base + 24'(k)}});
    end
    pulse(video_start);
    beam_detect_n = 1'b0;
    repeat (6) @(negedge clk);
    beam_detect_n = 1'b1;
    wait_for(video_line_done, 1'b1);
    repeat (3) @(negedge clk);
    chk(vq.size(), 0);
    test_done();
  end
endmodule : test_host_port_and_data_ops
